// ===== hw/rx_cmd_mailbox.sv
// Receive command decoder, descrambler and status word builder
`timescale 1ns/1ps
module rx_cmd_mailbox #(
  parameter int EXCH_CYCLES  = rx_cmd_pkg::EXCH_CYCLES,
  parameter int SYNC_LOSS    = rx_cmd_pkg::SYNC_LOSS_CYCLES,
  parameter int FIFO_DEPTH   = 32
) (
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst,
  // Mailbox command write (three bytes, index 0..2)
  input  wire logic        cmd_wr,
  input  wire logic [1:0]  cmd_idx,
  input  wire logic [7:0]  cmd_data,
  // Mailbox status words
  output logic [23:0]      tx_status_word,
  output logic [23:0]      rx_status_word,
  output logic             exch_tick,
  // Demodulator symbol stream
  input  wire logic        sym_valid,
  output logic             sym_ready,
  input  wire logic [3:0]  sym_data,
  // Analog-side status inputs
  input  wire logic        eq_loss,
  input  wire logic        poor_quality,
  input  wire logic        level_above_upper,
  input  wire logic        level_below_lower,
  // Clock sources
  input  wire logic        terminal_sync_clock_in,
  input  wire logic        rx_recovered_clock,
  // Clock and control outputs
  output logic             transmit_bit_clock,
  output logic             transmit_aux_clock_c,
  output logic             transmit_aux_clock_r,
  output logic             leased_threshold,
  output logic             originate_mode,
  output logic [1:0]       speaker_atten
);
  // --------------------------------------------------------------------------
  // Command registers
  // --------------------------------------------------------------------------
  logic [7:0] cmd0_r;
  logic [7:0] cmd1_r;
  logic [7:0] cmd_pend0_r;
  logic [7:0] cmd_pend1_r;
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      cmd_pend0_r <= rx_cmd_pkg::CMD_RST;
      cmd_pend1_r <= rx_cmd_pkg::CMD_RST;
      cmd0_r      <= rx_cmd_pkg::CMD_RST;
      cmd1_r      <= rx_cmd_pkg::CMD_RST;
    end else if (cmd_wr) begin
      if (cmd_idx == 2'h0) begin
        cmd_pend0_r <= cmd_data;
      end else if (cmd_idx == 2'h1) begin
        cmd_pend1_r <= cmd_data;
      end else if (cmd_idx == 2'h2 && cmd_data[rx_cmd_pkg::C2_RX_BIT]) begin
        // Third byte commits the word as a receive command
        cmd0_r <= cmd_pend0_r; // RL12
        cmd1_r <= cmd_pend1_r;
      end
    end
  end
  logic       sync_ext;
  logic [1:0] aux_sel;
  logic       dscr_en;
  logic       ones_en;
  logic       lo_rate;
  assign sync_ext = cmd0_r[rx_cmd_pkg::C0_TXSYNC_BIT];
  assign aux_sel  = cmd1_r[rx_cmd_pkg::C1_AUX_LSB +: 2];
  assign dscr_en  = cmd1_r[rx_cmd_pkg::C1_DSCR_BIT];
  assign ones_en  = cmd1_r[rx_cmd_pkg::C1_ONES_BIT];
  assign lo_rate  = cmd1_r[rx_cmd_pkg::C1_LORATE_BIT];
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      leased_threshold <= 1'b0;
      originate_mode   <= 1'b0;
      speaker_atten    <= 2'h0;
    end else begin
      leased_threshold <= cmd0_r[rx_cmd_pkg::C0_CDLEVEL_BIT]; // RL4
      originate_mode   <= cmd0_r[rx_cmd_pkg::C0_ORIG_BIT]; // RL5
      speaker_atten    <= cmd1_r[rx_cmd_pkg::C1_SPK_LSB +: 2]; // RL6
    end
  end
  // --------------------------------------------------------------------------
  // Transmit clock synchronisation
  // --------------------------------------------------------------------------
  logic        tsc_d_r;
  logic        rxc_d_r;
  logic        tsc_edge;
  logic        rxc_edge;
  logic [31:0] loss_cnt_r;
  logic        tsc_alive;
  logic [31:0] bit_cnt_r;
  logic        resync;
  assign tsc_edge  = terminal_sync_clock_in & ~tsc_d_r;
  assign rxc_edge  = rx_recovered_clock & ~rxc_d_r;
  assign tsc_alive = (loss_cnt_r < 32'(SYNC_LOSS));
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      tsc_d_r    <= 1'b0;
      rxc_d_r    <= 1'b0;
      loss_cnt_r <= 32'(SYNC_LOSS);
    end else begin
      tsc_d_r <= terminal_sync_clock_in;
      rxc_d_r <= rx_recovered_clock;
      if (tsc_edge) begin
        loss_cnt_r <= '0;
      end else if (tsc_alive) begin
        loss_cnt_r <= loss_cnt_r + 32'h1;
      end
    end
  end
  always_comb begin
    if (sync_ext) begin
      resync = tsc_edge & tsc_alive; // RL1 RL2
    end else begin
      resync = rxc_edge; // RL3
    end
  end
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      bit_cnt_r          <= '0;
      transmit_bit_clock <= 1'b0;
    end else if (resync) begin
      bit_cnt_r          <= '0;
      transmit_bit_clock <= 1'b1;
    end else if (bit_cnt_r >= 32'(rx_cmd_pkg::NOM_BIT_HALF - 1)) begin
      bit_cnt_r          <= '0;
      transmit_bit_clock <= ~transmit_bit_clock;
    end else begin
      bit_cnt_r <= bit_cnt_r + 32'h1;
    end
  end
  // --------------------------------------------------------------------------
  // Auxiliary clocks
  // --------------------------------------------------------------------------
  function automatic logic [31:0] aux_half(input logic [1:0] sel);
    case (sel)
      2'h0:    aux_half = 32'(rx_cmd_pkg::AUX_2400_HALF);
      2'h1:    aux_half = 32'(rx_cmd_pkg::AUX_1600_HALF);
      2'h2:    aux_half = 32'(rx_cmd_pkg::AUX_1200_HALF);
      default: aux_half = 32'(rx_cmd_pkg::AUX_600_HALF);
    endcase
  endfunction
  logic [31:0] aux_cnt_r;
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      aux_cnt_r            <= '0;
      transmit_aux_clock_c <= 1'b0;
      transmit_aux_clock_r <= 1'b0;
    end else if (resync) begin
      aux_cnt_r            <= '0;
      transmit_aux_clock_c <= 1'b1;
      transmit_aux_clock_r <= 1'b1;
    end else if (aux_cnt_r >= aux_half(aux_sel) - 32'h1) begin // RL7
      aux_cnt_r            <= '0;
      transmit_aux_clock_c <= ~transmit_aux_clock_c;
      transmit_aux_clock_r <= ~transmit_aux_clock_c;
    end else begin
      aux_cnt_r <= aux_cnt_r + 32'h1;
    end
  end
  // --------------------------------------------------------------------------
  // Symbol FIFO and serial descrambler
  // --------------------------------------------------------------------------
  logic       f_valid;
  logic       f_ready;
  logic [3:0] f_data;
  rx_fifo #(.WIDTH(4), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk_sys   (clk_sys),
    .rst       (rst),
    .in_valid  (sym_valid),
    .in_ready  (sym_ready),
    .in_data   (sym_data),
    .out_valid (f_valid),
    .out_ready (f_ready),
    .out_data  (f_data)
  );
  rx_cmd_pkg::rate_e rate;
  logic [2:0]  nbits;
  logic [2:0]  bit_idx_r;
  logic        busy_r;
  logic [3:0]  sym_r;
  logic [3:0]  raw_acc_r;
  logic [3:0]  dsc_acc_r;
  logic [16:0] sreg_r;
  logic [6:0]  ones_r;
  logic        in_bit;
  logic        cnt_bit;
  logic        dsc_bit;
  logic        pack_done_r;
  // Rate comes from command byte 1 bit 7 alone; MODE_V22BIS is never selected
  assign rate = lo_rate ? rx_cmd_pkg::MODE_V22LO : rx_cmd_pkg::MODE_V22;
  assign nbits = (rate == rx_cmd_pkg::MODE_V22LO) ? 3'h1 : 3'h2; // RL11
  assign f_ready = ~busy_r;
  assign in_bit  = sym_r[bit_idx_r[1:0]];
  assign cnt_bit = (ones_en && ones_r == 7'(rx_cmd_pkg::ONES_LIMIT)) ? ~in_bit : in_bit; // RL10
  assign dsc_bit = dscr_en ? (cnt_bit ^ sreg_r[rx_cmd_pkg::DSCR_TAP_A-1]
                              ^ sreg_r[rx_cmd_pkg::DSCR_TAP_B-1]) : in_bit; // RL8 RL9 RL22
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      busy_r      <= 1'b0;
      bit_idx_r   <= '0;
      sym_r       <= '0;
      raw_acc_r   <= 4'hF;
      dsc_acc_r   <= 4'hF;
      sreg_r      <= '0;
      ones_r      <= '0;
      pack_done_r <= 1'b0;
    end else begin
      pack_done_r <= 1'b0;
      if (!busy_r && f_valid) begin
        busy_r    <= 1'b1;
        sym_r     <= f_data;
        bit_idx_r <= '0;
        raw_acc_r <= 4'hF; // RL17
        dsc_acc_r <= 4'hF; // RL17
      end else if (busy_r) begin
        raw_acc_r[bit_idx_r[1:0]] <= in_bit; // RL16 RL19
        dsc_acc_r[bit_idx_r[1:0]] <= dsc_bit; // RL19
        if (dscr_en) begin
          sreg_r <= {sreg_r[15:0], cnt_bit};
        end
        if (!ones_en || !in_bit || ones_r == 7'(rx_cmd_pkg::ONES_LIMIT)) begin
          ones_r <= '0;
        end else begin
          ones_r <= ones_r + 7'h1;
        end
        bit_idx_r <= bit_idx_r + 3'h1;
        if (bit_idx_r + 3'h1 == nbits) begin
          busy_r      <= 1'b0;
          pack_done_r <= 1'b1;
        end
      end
    end
  end
  // --------------------------------------------------------------------------
  // Exchange pacing and status words
  // --------------------------------------------------------------------------
  logic [31:0] exch_cnt_r;
  logic [3:0]  raw_hold_r;
  logic [3:0]  dsc_hold_r;
  logic        cd_r;
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      exch_cnt_r <= '0;
      exch_tick  <= 1'b0;
    end else if (exch_cnt_r >= 32'(EXCH_CYCLES - 1)) begin // RL18
      exch_cnt_r <= '0;
      exch_tick  <= 1'b1;
    end else begin
      exch_cnt_r <= exch_cnt_r + 32'h1;
      exch_tick  <= 1'b0;
    end
  end
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      raw_hold_r <= 4'hF;
      dsc_hold_r <= 4'hF;
      cd_r       <= 1'b1;
    end else begin
      if (pack_done_r) begin
        raw_hold_r <= raw_acc_r;
        dsc_hold_r <= dsc_acc_r;
      end
      if (level_above_upper) begin
        cd_r <= 1'b0; // RL21
      end else if (level_below_lower) begin
        cd_r <= 1'b1; // RL21
      end
    end
  end
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      tx_status_word <= rx_cmd_pkg::TX_STATUS_RST; // RL14
      rx_status_word <= 24'h000001;
    end else if (exch_tick) begin
      tx_status_word <= rx_cmd_pkg::TX_STATUS_RST; // RL14
      rx_status_word <= {3'h0, dsc_hold_r, 1'b0,
                         1'b0, cd_r, poor_quality, eq_loss, 4'h0, // RL20
                         3'h0, raw_hold_r, 1'b1}; // RL15 RL16
    end
  end
endmodule

// ===== hw/rx_cmd_pkg.sv
// Constants for the receive command and status mailbox block
// ----------------------------------------------------------------------------
// Contract
// RL1 - Command byte 0 bit 5 set locks transmit clocks to terminal sync clock
// RL2 - Missing terminal sync clock while selected lets transmit clocks free-run
// RL3 - Command byte 0 bit 5 clear slaves transmit clocks to receive clocks
// RL4 - Command byte 0 bit 6 picks switched or leased carrier thresholds
// RL5 - Command byte 0 bit 7 picks answer (low) or originate (high) channel
// RL6 - Command byte 1 bits 1:0 set speaker attenuation mute/0/6/12 dB
// RL7 - Command byte 1 bits 4:3 set aux clock 2400/1600/1200/600 Hz
// RL8 - Command byte 1 bit 5 enables descrambler, else data bypasses it
// RL9 - Descrambler multiplies stream by the far-end scrambler polynomial
// RL10 - Byte 1 bit 6 enables ones counter; after 64 ones invert next input
// RL11 - Command byte 1 bit 7 selects 600 bit/s, clear selects 1200 bit/s
// RL12 - Processor sets byte 2 bit 0 for receive command, bits 7:1 zero
// RL13 - Processor writes zero to every reserved command bit
// RL14 - Transmit status byte 0 bit 0 low; other transmit status bits reserved
// RL15 - Receive status byte 0 bit 0 is one
// RL16 - Receive status byte 0 bits 4:1 carry data before descrambler
// RL17 - Unused data positions in receive status read as one; the reset word 24'h000001 holds them at zero until the first exchange
// RL18 - Mailbox words are exchanged at 600 per second
// RL19 - Earliest received bit goes in bit position 1
// RL20 - Status byte 1 bit 4 flags equalisation loss, bit 5 poor quality
// RL21 - Status byte 1 bit 6 low above upper threshold, high below lower
// RL22 - Descrambler polynomial is 1 + x^-14 + x^-17
// ----------------------------------------------------------------------------
package rx_cmd_pkg;
  localparam int CLK_HZ           = 200_000_000;
  localparam int EXCH_PER_S       = 600;
  localparam int EXCH_CYCLES      = CLK_HZ / EXCH_PER_S;
  localparam int NOM_BIT_HZ       = 1200;
  localparam int NOM_BIT_HALF     = CLK_HZ / (2 * NOM_BIT_HZ);
  localparam int AUX_2400_HALF    = CLK_HZ / (2 * 2400);
  localparam int AUX_1600_HALF    = CLK_HZ / (2 * 1600);
  localparam int AUX_1200_HALF    = CLK_HZ / (2 * 1200);
  localparam int AUX_600_HALF     = CLK_HZ / (2 * 600);
  localparam int SYNC_LOSS_CYCLES = 2 * CLK_HZ / NOM_BIT_HZ;
  localparam int ONES_LIMIT       = 64;
  localparam int DSCR_TAP_A       = 14;
  localparam int DSCR_TAP_B       = 17;
  // Command byte 0 fields
  localparam int C0_TXSYNC_BIT    = 5;
  localparam int C0_CDLEVEL_BIT   = 6;
  localparam int C0_ORIG_BIT      = 7;
  // Command byte 1 fields
  localparam int C1_SPK_LSB       = 0;
  localparam int C1_AUX_LSB       = 3;
  localparam int C1_DSCR_BIT      = 5;
  localparam int C1_ONES_BIT      = 6;
  localparam int C1_LORATE_BIT    = 7;
  // Command byte 2 fields
  localparam int C2_RX_BIT        = 0;
  // Status fields
  localparam int S0_ID_BIT        = 0;
  localparam int S_DATA_LSB       = 1;
  localparam int S1_EQ_BIT        = 4;
  localparam int S1_QUAL_BIT      = 5;
  localparam int S1_CD_BIT        = 6;
  localparam logic [23:0] TX_STATUS_RST = 24'h000000;
  localparam logic [7:0]  CMD_RST       = 8'h00;
  typedef enum logic [1:0] {
    MODE_V22BIS = 2'h0,
    MODE_V22    = 2'h1,
    MODE_V22LO  = 2'h3
  } rate_e;
endpackage

// ===== hw/rx_fifo.sv
// Parameterised valid/ready FIFO for received data symbols
`timescale 1ns/1ps
module rx_fifo #(
  parameter int WIDTH = 4,
  parameter int DEPTH = 32
) (
  // Clock and reset
  input  wire logic             clk_sys,
  input  wire logic             rst,
  // Fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_r;
  logic [AW-1:0]    rd_r;
  logic [AW:0]      cnt_r;
  logic             push;
  logic             pop;
  assign in_ready  = (cnt_r != (AW+1)'(DEPTH));
  assign out_valid = (cnt_r != '0);
  assign out_data  = mem[rd_r];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;
  always_ff @(posedge clk_sys) begin
    if (push) begin
      mem[wr_r] <= in_data;
    end
  end
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      wr_r  <= '0;
      rd_r  <= '0;
      cnt_r <= '0;
    end else begin
      if (push) begin
        wr_r <= (wr_r == AW'(DEPTH-1)) ? '0 : wr_r + 1'b1;
      end
      if (pop) begin
        rd_r <= (rd_r == AW'(DEPTH-1)) ? '0 : rd_r + 1'b1;
      end
      cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

// ===== tb/ctrl_proc_model.sv
// Control processor model issuing three-byte receive command words
`timescale 1ns/1ps
module ctrl_proc_model (
  // Clock and request
  input  wire logic       clk_sys,
  input  wire logic       go,
  input  wire logic [7:0] b0,
  input  wire logic [7:0] b1,
  input  wire logic [7:0] b2,
  // Mailbox write side
  output logic            cmd_wr,
  output logic [1:0]      cmd_idx,
  output logic [7:0]      cmd_data
);
  logic [1:0] step_r = 2'h0;
  initial begin
    cmd_wr   = 1'b0;
    cmd_idx  = 2'h0;
    cmd_data = 8'h00;
  end
  always @(negedge clk_sys) begin
    if (go || step_r != 2'h0) begin
      cmd_wr  <= 1'b1;
      cmd_idx <= step_r;
      step_r  <= (step_r == 2'h2) ? 2'h0 : step_r + 2'h1;
      case (step_r)
        2'h0: cmd_data <= b0;
        2'h1: cmd_data <= b1 & 8'hFB;
        default: cmd_data <= {7'h00, b2[0]};
      endcase
    end else begin
      // Released lines wander so stale values are never mistaken for data
      cmd_wr   <= 1'b0;
      cmd_idx  <= ~cmd_idx;
      cmd_data <= ~cmd_data;
    end
  end
endmodule

// ===== tb/rx_cmd_mailbox_monitor.sv
// Assertion checker for the receive command mailbox ports
`timescale 1ns/1ps
module rx_cmd_monitor #(
  parameter int EXCH_CYCLES = 50
) (
  // Clock and reset
  input wire logic        clk_sys,
  input wire logic        rst,
  // Command writes
  input wire logic        cmd_wr,
  input wire logic [1:0]  cmd_idx,
  input wire logic [7:0]  cmd_data,
  // Status and controls
  input wire logic [23:0] tx_status_word,
  input wire logic [23:0] rx_status_word,
  input wire logic        exch_tick,
  input wire logic        leased_threshold,
  input wire logic        originate_mode,
  input wire logic [1:0]  speaker_atten
);
  logic [7:0] pend0_r;
  logic [7:0] pend1_r;
  logic [7:0] snap0_r;
  logic [7:0] snap1_r;
  logic       seen_r;
  logic       rst_d_r;
  int         cnt_r;
  logic       commit;
  assign commit = cmd_wr && cmd_idx == 2'h2 && cmd_data[0];
  // ---------------------------------------------------------------
  // Shadow of the committed command bytes
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (cmd_wr && cmd_idx == 2'h0) pend0_r <= cmd_data;
    if (cmd_wr && cmd_idx == 2'h1) pend1_r <= cmd_data;
    if (commit) begin
      snap0_r <= pend0_r;
      snap1_r <= pend1_r;
    end
  end
  always_ff @(posedge clk_sys) begin
    rst_d_r <= rst;
    if (rst) begin
      cnt_r  <= 0;
      seen_r <= 1'b0;
    end else if (exch_tick) begin
      cnt_r  <= 0;
      seen_r <= 1'b1;
    end else begin
      cnt_r <= cnt_r + 1;
    end
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  a_tx_status_zero: assert property (tx_status_word == 24'h000000)
    else $error("transmit status word not zero");
  a_rx_id_bit: assert property (rx_status_word[0] == 1'b1)
    else $error("receive status id bit low");
  a_tick_period: assert property (seen_r |-> (exch_tick == (cnt_r == EXCH_CYCLES - 1)))
    else $error("exchange tick off period");
  a_status_hold: assert property (disable iff (rst || rst_d_r)
    $changed(rx_status_word) |-> exch_tick || $past(exch_tick) || $past(exch_tick, 2))
    else $error("status word changed between exchanges");
  a_orig_mode: assert property (commit |-> ##3 originate_mode == snap0_r[7])
    else $error("channel select wrong");
  a_cd_level: assert property (commit |-> ##3 leased_threshold == snap0_r[6])
    else $error("threshold pair wrong");
  a_spk_atten: assert property (commit |-> ##3 speaker_atten == snap1_r[1:0])
    else $error("speaker attenuation wrong");
  a_bad_commit: assert property ((cmd_wr && cmd_idx == 2'h2 && !cmd_data[0]) |=>
    $stable({originate_mode, leased_threshold, speaker_atten}) [*3])
    else $error("controls changed without receive mark");
endmodule
bind rx_cmd_mailbox rx_cmd_monitor #(.EXCH_CYCLES(EXCH_CYCLES)) i_rx_cmd_monitor (
  .clk_sys(clk_sys), .rst(rst), .cmd_wr(cmd_wr), .cmd_idx(cmd_idx), .cmd_data(cmd_data),
  .tx_status_word(tx_status_word), .rx_status_word(rx_status_word), .exch_tick(exch_tick),
  .leased_threshold(leased_threshold), .originate_mode(originate_mode),
  .speaker_atten(speaker_atten));

// ===== tb/tb_top.sv
// Self-checking bench for the receive command mailbox
`timescale 1ns/1ps
module tb_top;
  localparam int EXCH  = 50;
  localparam int LIMIT = 20000;
  logic        clk_sys, rst, go, sym_valid, sym_ready, exch_tick, cmd_wr;
  logic        eq_loss, poor_quality, level_above_upper, level_below_lower;
  logic        terminal_sync_clock_in, rx_recovered_clock, leased_threshold, originate_mode;
  logic        transmit_bit_clock, transmit_aux_clock_c, transmit_aux_clock_r;
  logic [7:0]  b0, b1, b2, cmd_data;
  logic [1:0]  cmd_idx, speaker_atten;
  logic [3:0]  sym_data;
  logic [23:0] tx_status_word, rx_status_word;
  int          n_fail, total_checks, cyc, refused;
  rx_cmd_mailbox #(.EXCH_CYCLES(EXCH), .SYNC_LOSS(20), .FIFO_DEPTH(32)) i_rx_cmd_mailbox (
    .clk_sys(clk_sys), .rst(rst), .cmd_wr(cmd_wr), .cmd_idx(cmd_idx), .cmd_data(cmd_data),
    .tx_status_word(tx_status_word), .rx_status_word(rx_status_word), .exch_tick(exch_tick),
    .sym_valid(sym_valid), .sym_ready(sym_ready), .sym_data(sym_data), .eq_loss(eq_loss),
    .poor_quality(poor_quality), .level_above_upper(level_above_upper),
    .level_below_lower(level_below_lower), .terminal_sync_clock_in(terminal_sync_clock_in),
    .rx_recovered_clock(rx_recovered_clock), .transmit_bit_clock(transmit_bit_clock),
    .transmit_aux_clock_c(transmit_aux_clock_c), .transmit_aux_clock_r(transmit_aux_clock_r),
    .leased_threshold(leased_threshold), .originate_mode(originate_mode),
    .speaker_atten(speaker_atten));
  ctrl_proc_model i_ctrl_proc_model (.clk_sys(clk_sys), .go(go), .b0(b0), .b1(b1), .b2(b2),
    .cmd_wr(cmd_wr), .cmd_idx(cmd_idx), .cmd_data(cmd_data));
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  always @(negedge clk_sys) begin
    rx_recovered_clock     <= cyc[3];
    terminal_sync_clock_in <= cyc[4];
  end
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      n_fail++;
      final_report();
    end
  end
  // ---------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------
  task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic final_report;
    $display("checks=%0d mismatches=%0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic wr_cmd(input logic [7:0] a, input logic [7:0] c, input logic [7:0] d);
    b0 <= a;
    b1 <= c;
    b2 <= d;
    go <= 1'b1;
    @(negedge clk_sys);
    go <= 1'b0;
    repeat (8) @(negedge clk_sys);
  endtask
  task automatic wait_tick;
    int k;
    k = 0;
    while (exch_tick !== 1'b1 && k < 200) begin
      @(negedge clk_sys);
      k++;
    end
    if (k == 200) n_fail++;
    repeat (3) @(negedge clk_sys);
  endtask
  task automatic send_sym(input logic [3:0] d, input logic [23:0] mask, input logic [23:0] exp);
    int k;
    k = 0;
    wait_tick();
    sym_valid <= 1'b1;
    sym_data  <= d;
    // Ready is looked at mid-cycle, where it stands for the coming edge
    while (sym_ready !== 1'b1 && k < 100) begin
      @(negedge clk_sys);
      k++;
    end
    @(negedge clk_sys);
    sym_valid <= 1'b0;
    sym_data  <= ~d;
    wait_tick();
    chk(rx_status_word & mask, exp);
  endtask
  // ---------------------------------------------------------------
  // Test sequence
  // ---------------------------------------------------------------
  initial begin
    {rst, go, sym_valid, eq_loss, poor_quality, level_above_upper, level_below_lower} = 7'h41;
    {rx_recovered_clock, terminal_sync_clock_in} = 2'h0;
    {b0, b1, b2, sym_data} = 28'h0000000;
    n_fail       = 0;
    total_checks = 0;
    cyc          = 0;
    refused      = 0;
    repeat (4) @(negedge clk_sys);
    rst <= 1'b0;
    @(negedge clk_sys);
    chk(tx_status_word, 24'h000000);
    chk(rx_status_word, 24'h000001);
    for (int i = 0; i < 4; i++) begin
      wr_cmd({i[1:0], 6'h02}, {3'h0, i[1:0], 1'b0, i[1:0]}, 8'h01);
      chk({originate_mode, leased_threshold, speaker_atten}, {i[1:0], i[1:0]});
    end
    wr_cmd(8'h00, 8'h00, 8'h00);
    chk({originate_mode, leased_threshold, speaker_atten}, 24'h00000F);
    $display("command decode test done");
    wr_cmd(8'h02, 8'h00, 8'h01);
    {eq_loss, level_above_upper} = 2'h3;
    send_sym(4'h2, 24'h1E701E, 24'h1C101C);
    wr_cmd(8'h02, 8'h80, 8'h01);
    {eq_loss, level_above_upper, poor_quality, level_below_lower} = 4'h3;
    send_sym(4'h0, 24'h1E701E, 24'h1C601C);
    wr_cmd(8'h02, 8'h60, 8'h01);
    {poor_quality, level_below_lower, level_above_upper} = 3'h1;
    send_sym(4'h1, 24'h1E701E, 24'h1A001A);
    $display("status packing test done");
    sym_valid <= 1'b1;
    sym_data  <= 4'h3;
    repeat (120) begin
      @(negedge clk_sys);
      if (sym_ready === 1'b0) refused++;
    end
    @(negedge clk_sys);
    sym_valid <= 1'b0;
    chk(24'(refused != 0), 24'h000001);
    repeat (200) @(negedge clk_sys);
    chk(24'(sym_ready), 24'h000001);
    $display("buffer fill test done");
    final_report();
  end
endmodule
